// file: sss_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module sss_drive_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] demand,
   input  wire logic        drive_en,
   input  wire logic        slow,
   input  wire logic        pin,
   input  wire logic [15:0] pin_val,
   output logic [15:0]      fb
);
   logic        [15:0] tgt;
   logic signed [15:0] err;
   // Target is the demand while the drive is enabled, zero while coasting
   assign tgt = drive_en ? demand : 16'h0000;
   assign err = $signed(tgt - fb);
   // Shaft follows at once or 10 counts a clock; a pinned shaft ignores it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         fb <= 16'h0000;
      else if (pin)
         fb <= pin_val;
      else if (!slow || (err < 16'sh000A && err > -16'sh000A))
         fb <= tgt;
      else if (err > 16'sh0000)
         fb <= fb + 16'h000A;
      else
         fb <= fb - 16'h000A;
   end
endmodule : sss_drive_model
`default_nettype wire

// file: sss_pkg.sv
`default_nettype none
package sss_pkg;
   // Fixed-point percent: signed, 0.01 % per count
   localparam int          PCT_W          = 16;
   localparam int          DIFF_W         = 18;
   localparam logic [15:0] PCT_FULL       = 16'h2710;    // 100.00 %
   localparam logic [15:0] PCT_FULL_CUR   = 16'h4E20;    // 200.00 %
   localparam logic [15:0] ZERO_LVL_DEF   = 16'h00C8;    // 2.00 %
   localparam logic [15:0] ZERO_HYST      = 16'h0032;    // 0.50 %
   localparam logic [15:0] EARLY_DIS_LVL  = 16'h0019;    // 0.25 %
   // Timer values are 0.1 s units
   localparam int          TMR_W          = 13;
   localparam logic [12:0] TMR_ONE        = 13'h0001;
   localparam logic [3:0]  SUB_LAST       = 4'h9;        // Ramp ticks per 0.1 s, minus one
   localparam logic [15:0] RAMP_STEP_NUM  = 16'h03E8;    // Full scale per ramp tick times 0.1 s
   localparam logic [15:0] FADE_DIV       = 16'h000A;    // Fade rate per 0.1 s step
   // Time base
   localparam int          CLK_PERIOD_PS  = 8000;
   localparam int          RAMP_TICK_MS   = 10;
   localparam int          RAMP_TICK_CYC  = (RAMP_TICK_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int          DIV_W          = 24;
   // Sequencer states, Gray along the normal path
   typedef enum logic [2:0] {
      SSS_IDLE  = 3'h0,
      SSS_RUN   = 3'h1,
      SSS_NSTOP = 3'h3,
      SSS_HOLD  = 3'h2,
      SSS_FADE  = 3'h6,
      SSS_WAIT  = 3'h7,
      SSS_FSTOP = 3'h5
   } sss_state_t;
endpackage : sss_pkg
`default_nettype wire

// file: sss_sequencer.sv
// Contract
// R1 - Speed near zero below level, 0.5% hysteresis
// R2 - Demand near zero below level, same hysteresis
// R3 - Motor stopped only when both flags true
// R4 - Zero level 0..100%, default 2%, shared
// R5 - Stopped hold quenches loops, contactor stays on
// R6 - Quench held until motor stopped drops
// R7 - Tracking while ramp error below tolerance
// R8 - Run removal ramps demand to zero
// R9 - Non-regen no faster than coast rate
// R10 - Normal stop timeout drops contactor, disables
// R11 - Contactor held for hold time after zero
// R12 - Early disable when level high, no fade
// R13 - Fast stop low starts timer, fast ramp
// R14 - Fast stop ends at stop speed level
// R15 - Fast stop timeout drops contactor, disables
// R16 - Fast stop caps current, lower limits win
// R17 - Stops inactive before run, else disabled
// R18 - Current faded at fade rate after hold
// R19 - Signed 0.01% values, magnitudes, 0.1s timers
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer #(
   parameter int RAMP_TICK_CYC = sss_pkg::RAMP_TICK_CYC
) (
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   input  wire logic [15:0] SPEED_FB,
   input  wire logic [15:0] STANDSTILL_IN,
   input  wire logic [15:0] SPEED_SETPOINT,
   input  wire logic        ZERO_LEVEL_SET,
   input  wire logic [15:0] ZERO_LEVEL,
   input  wire logic        STANDSTILL_EN,
   input  wire logic [15:0] RAMP_IN,
   input  wire logic [15:0] RAMP_OUT,
   input  wire logic [15:0] TRACKING_TOLERANCE,
   input  wire logic        RUN_TERMINAL,
   input  wire logic        FAST_STOP_TERMINAL,
   input  wire logic        COAST_STOP_N,
   input  wire logic        REGEN,
   input  wire logic [12:0] NORMAL_RAMP_TIME,
   input  wire logic [12:0] COAST_RAMP_TIME,
   input  wire logic [12:0] STOP_TIMEOUT,
   input  wire logic [12:0] CONTACTOR_HOLD,
   input  wire logic [15:0] STOP_SPEED_LEVEL,
   input  wire logic        CURRENT_DEMAND_CUT,
   input  wire logic [15:0] CURRENT_FADE_RATE,
   input  wire logic [12:0] FAST_RAMP_DURATION,
   input  wire logic [12:0] FAST_STOP_TIMEOUT,
   input  wire logic [15:0] FAST_STOP_CURRENT_CAP,
   input  wire logic [15:0] CURRENT_LIMIT_IN,
   output logic             SPEED_NEAR_ZERO,
   output logic             DEMAND_NEAR_ZERO,
   output logic             MOTOR_STOPPED_FLAG,
   output logic             ZERO_SPEED_RELAY,
   output logic             TRACKING_FLAG,
   output logic             LOOPS_QUENCH,
   output logic             THYRISTOR_FIRING,
   output logic             CONTACTOR_ON,
   output logic             RUN_LED,
   output logic             DRIVE_EN,
   output logic [15:0]      SPEED_DEMAND,
   output logic [15:0]      CURRENT_LIMIT,
   output logic [15:0]      CURRENT_SCALE,
   output logic [2:0]       SEQ_STATE
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Magnitude of a signed percent value
   function automatic logic [15:0] sss_mag(input logic [15:0] v);
      sss_mag = v[15] ? 16'(-v) : v;
   endfunction : sss_mag

   // Per-ramp-tick step for a full-scale ramp over t tenths of a second
   function automatic logic [15:0] sss_step(input logic [12:0] t);
      logic [15:0] q;
      q = (t == 13'h0000) ? sss_pkg::RAMP_STEP_NUM : 16'(sss_pkg::RAMP_STEP_NUM / 16'(t));
      sss_step = (q == 16'h0000) ? 16'h0001 : q;
   endfunction : sss_step

   // Sign extension to the difference width
   function automatic logic signed [sss_pkg::DIFF_W-1:0] sss_diff_s(input logic [15:0] v);
      sss_diff_s = {{(sss_pkg::DIFF_W-16){v[15]}}, v};
   endfunction : sss_diff_s

   sss_pkg::sss_state_t state_r;
   sss_pkg::sss_state_t state_nxt;
   logic [sss_pkg::DIV_W-1:0] div_r;
   logic [3:0]                sub_r;
   logic                      ramp_tick;
   logic                      tenth_tick;
   logic [sss_pkg::TMR_W-1:0] tmr_r;
   logic [15:0]               lvl;
   logic [15:0]               fb_mag;
   logic [15:0]               dem_mag;
   logic                      snz_r;
   logic                      dnz_r;
   logic                      stopped;
   logic                      at_stop_speed;
   logic                      early_dis;
   logic                      start_ok;
   logic [12:0]               nstop_time;
   logic [15:0]               step;
   logic [16:0]               err_mag;
   logic [15:0]               dem_r;
   logic [15:0]               cur_r;

   ////////////////////////////////////////////////////////////////////////////
   // Time base: 10 ms ramp tick and 0.1 s timer tick

   assign ramp_tick  = (div_r == sss_pkg::DIV_W'(RAMP_TICK_CYC - 1));
   assign tenth_tick = ramp_tick && (sub_r == sss_pkg::SUB_LAST);

   // Clock divider
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         div_r <= '0;
         sub_r <= 4'h0;
      end
      else if (ramp_tick)
      begin
         div_r <= '0;
         sub_r <= (sub_r == sss_pkg::SUB_LAST) ? 4'h0 : sub_r + 4'h1;
      end
      else
      begin
         div_r <= div_r + sss_pkg::DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standstill detection

   // Zero level: default until set, clamped to full scale
   assign lvl = !ZERO_LEVEL_SET ? sss_pkg::ZERO_LVL_DEF :                      // see R4
                (ZERO_LEVEL > sss_pkg::PCT_FULL) ? sss_pkg::PCT_FULL : ZERO_LEVEL;
   assign fb_mag  = sss_mag(SPEED_FB);                                          // see R19
   assign dem_mag = sss_mag(STANDSTILL_IN);

   // Near-zero flags: set below level, clear at level plus hysteresis
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         snz_r <= 1'b0;
         dnz_r <= 1'b0;
      end
      else
      begin
         if (fb_mag < lvl)
            snz_r <= 1'b1;                                                      // see R1
         else if ({1'b0, fb_mag} >= {1'b0, lvl} + {1'b0, sss_pkg::ZERO_HYST})
            snz_r <= 1'b0;
         if (dem_mag < lvl)
            dnz_r <= 1'b1;                                                      // see R2
         else if ({1'b0, dem_mag} >= {1'b0, lvl} + {1'b0, sss_pkg::ZERO_HYST})
            dnz_r <= 1'b0;
      end
   end

   assign stopped = snz_r && dnz_r;                                            // see R3

   // Ramp tracking error
   assign err_mag = (sss_diff_s(RAMP_IN) >= sss_diff_s(RAMP_OUT)) ?
                    17'(sss_diff_s(RAMP_IN) - sss_diff_s(RAMP_OUT)) :
                    17'(sss_diff_s(RAMP_OUT) - sss_diff_s(RAMP_IN));

   ////////////////////////////////////////////////////////////////////////////
   // Stop sequencer

   assign at_stop_speed = fb_mag < STOP_SPEED_LEVEL;
   assign early_dis     = ((STOP_SPEED_LEVEL > sss_pkg::EARLY_DIS_LVL) || CURRENT_DEMAND_CUT)
                          && (CURRENT_FADE_RATE == 16'h0000);                   // see R12
   assign start_ok      = RUN_TERMINAL && FAST_STOP_TERMINAL && COAST_STOP_N;  // see R17
   assign nstop_time    = (!REGEN && (COAST_RAMP_TIME > NORMAL_RAMP_TIME)) ?
                          COAST_RAMP_TIME : NORMAL_RAMP_TIME;                   // see R9

   // Next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         sss_pkg::SSS_IDLE:
            if (start_ok)
               state_nxt = sss_pkg::SSS_RUN;
            else if (RUN_TERMINAL)
               state_nxt = sss_pkg::SSS_WAIT;                                   // see R17
         sss_pkg::SSS_RUN:
            if (!COAST_STOP_N)
               state_nxt = sss_pkg::SSS_WAIT;
            else if (!FAST_STOP_TERMINAL)
               state_nxt = sss_pkg::SSS_FSTOP;                                  // see R13
            else if (!RUN_TERMINAL)
               state_nxt = sss_pkg::SSS_NSTOP;                                  // see R8
         sss_pkg::SSS_NSTOP:
            if (!COAST_STOP_N)
               state_nxt = sss_pkg::SSS_WAIT;
            else if (!FAST_STOP_TERMINAL)
               state_nxt = sss_pkg::SSS_FSTOP;
            else if (at_stop_speed)
               state_nxt = sss_pkg::SSS_HOLD;                                   // see R11
            else if (tmr_r >= STOP_TIMEOUT)
               state_nxt = sss_pkg::SSS_WAIT;                                   // see R10
         sss_pkg::SSS_HOLD:
            if (!COAST_STOP_N)
               state_nxt = sss_pkg::SSS_WAIT;
            else if (tmr_r >= CONTACTOR_HOLD)
               state_nxt = (CURRENT_FADE_RATE != 16'h0000) ?
                           sss_pkg::SSS_FADE : sss_pkg::SSS_WAIT;               // see R18
         sss_pkg::SSS_FADE:
            if (cur_r == 16'h0000)
               state_nxt = sss_pkg::SSS_WAIT;
         sss_pkg::SSS_FSTOP:
            if (!COAST_STOP_N || at_stop_speed)
               state_nxt = sss_pkg::SSS_WAIT;                                   // see R14
            else if (tmr_r >= FAST_STOP_TIMEOUT)
               state_nxt = sss_pkg::SSS_WAIT;                                   // see R15
         sss_pkg::SSS_WAIT:
            if (!RUN_TERMINAL)
               state_nxt = sss_pkg::SSS_IDLE;
         default:
            state_nxt = sss_pkg::SSS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         state_r <= sss_pkg::SSS_IDLE;
      else
         state_r <= state_nxt;
   end

   // Stop timer in 0.1 s steps, restarted on every state change
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         tmr_r <= '0;
      else if (state_nxt != state_r)
         tmr_r <= '0;                                                           // see R10
      else if (tenth_tick && (tmr_r != '1))
         tmr_r <= tmr_r + sss_pkg::TMR_ONE;                                     // see R19
   end

   ////////////////////////////////////////////////////////////////////////////
   // Speed demand and current

   assign step = (state_r == sss_pkg::SSS_FSTOP) ? sss_step(FAST_RAMP_DURATION)
                                                 : sss_step(nstop_time);

   // Demand follows setpoint in run, ramps to zero while stopping
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         dem_r <= 16'h0000;
      else if (state_nxt == sss_pkg::SSS_RUN)
         dem_r <= SPEED_SETPOINT;
      else if ((state_nxt == sss_pkg::SSS_NSTOP) || (state_nxt == sss_pkg::SSS_FSTOP))
      begin
         if (ramp_tick)
         begin
            if (sss_mag(dem_r) <= step)
               dem_r <= 16'h0000;
            else if (dem_r[15])
               dem_r <= dem_r + step;                                           // see R8
            else
               dem_r <= dem_r - step;                                           // see R13
         end
      end
      else
         dem_r <= 16'h0000;
   end

   // Current scale: full, faded after the hold at the fade rate
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         cur_r <= sss_pkg::PCT_FULL;
      else if (state_r != sss_pkg::SSS_FADE)
         cur_r <= sss_pkg::PCT_FULL;
      else if (tenth_tick)
         cur_r <= (cur_r <= CURRENT_FADE_RATE / sss_pkg::FADE_DIV) ? 16'h0000 :
                  cur_r - CURRENT_FADE_RATE / sss_pkg::FADE_DIV;                // see R18
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, registered except MOTOR_STOPPED_FLAG, an AND of the two flags, and LOOPS_QUENCH and THYRISTOR_FIRING, which decode STANDSTILL_EN

   // Ramp tracking flag
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         TRACKING_FLAG <= 1'b0;
      else
         TRACKING_FLAG <= err_mag < {1'b0, TRACKING_TOLERANCE};                 // see R7
   end

   // Contactor, enable and current limit from the next state
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         CONTACTOR_ON  <= 1'b0;
         DRIVE_EN      <= 1'b0;
         CURRENT_LIMIT <= 16'h0000;
      end
      else
      begin
         CONTACTOR_ON  <= (state_nxt == sss_pkg::SSS_RUN) || (state_nxt == sss_pkg::SSS_NSTOP)
                          || (state_nxt == sss_pkg::SSS_HOLD)
                          || (state_nxt == sss_pkg::SSS_FSTOP);                 // see R11
         DRIVE_EN      <= (state_nxt == sss_pkg::SSS_RUN) || (state_nxt == sss_pkg::SSS_NSTOP)
                          || (state_nxt == sss_pkg::SSS_FSTOP)
                          || ((state_nxt == sss_pkg::SSS_HOLD) && !early_dis);  // see R12
         if (state_nxt == sss_pkg::SSS_FSTOP)
            CURRENT_LIMIT <= (FAST_STOP_CURRENT_CAP < CURRENT_LIMIT_IN) ?
                             FAST_STOP_CURRENT_CAP : CURRENT_LIMIT_IN;          // see R16
         else
            CURRENT_LIMIT <= CURRENT_LIMIT_IN;
      end
   end

   assign SPEED_NEAR_ZERO    = snz_r;
   assign DEMAND_NEAR_ZERO   = dnz_r;
   assign MOTOR_STOPPED_FLAG = stopped;
   assign ZERO_SPEED_RELAY   = snz_r;                                          // see R4
   assign RUN_LED            = CONTACTOR_ON;                                   // see R5
   assign LOOPS_QUENCH       = STANDSTILL_EN && stopped && DRIVE_EN;           // see R6
   assign THYRISTOR_FIRING   = DRIVE_EN && !LOOPS_QUENCH;                      // see R5
   assign SPEED_DEMAND       = dem_r;
   assign CURRENT_SCALE      = cur_r;
   assign SEQ_STATE          = state_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_in_fstop;
      state_r == sss_pkg::SSS_FSTOP && COAST_STOP_N;
   endsequence

   sequence s_reach_stop;
      at_stop_speed;
   endsequence

   chk_speed_set: assert property (fb_mag < lvl |=> SPEED_NEAR_ZERO) // see R1
      else $error("speed near zero not set below level");
   chk_speed_hyst: assert property (                                  // see R1
      {1'b0, fb_mag} >= {1'b0, lvl} + {1'b0, sss_pkg::ZERO_HYST} |=> !SPEED_NEAR_ZERO)
      else $error("speed near zero not cleared above hysteresis");
   chk_demand_flag: assert property (dem_mag < lvl |=> DEMAND_NEAR_ZERO) // see R2
      else $error("demand near zero not set below level");
   chk_stopped_both: assert property (                                // see R3
      MOTOR_STOPPED_FLAG |-> SPEED_NEAR_ZERO && DEMAND_NEAR_ZERO)
      else $error("motor stopped without both flags");
   chk_quench_hold: assert property (                                 // see R5
      LOOPS_QUENCH |-> !THYRISTOR_FIRING && CONTACTOR_ON && RUN_LED)
      else $error("quench lost contactor or kept firing");
   chk_track_flag: assert property (                                  // see R7
      err_mag < {1'b0, TRACKING_TOLERANCE} |=> TRACKING_FLAG)
      else $error("tracking flag missing");
   chk_nstop_entry: assert property (                                 // see R8
      state_r == sss_pkg::SSS_RUN && COAST_STOP_N && FAST_STOP_TERMINAL && !RUN_TERMINAL
      |=> state_r == sss_pkg::SSS_NSTOP ##0 CONTACTOR_ON)
      else $error("normal stop not entered");
   chk_fstop_end: assert property (s_in_fstop ##0 s_reach_stop        // see R14
      |=> !CONTACTOR_ON && !DRIVE_EN)
      else $error("fast stop not ended at stop speed");
   chk_fstop_cap: assert property (                                   // see R16
      state_r == sss_pkg::SSS_FSTOP && $stable(CURRENT_LIMIT_IN)
      && $stable(FAST_STOP_CURRENT_CAP)
      |-> CURRENT_LIMIT <= CURRENT_LIMIT_IN && CURRENT_LIMIT <= FAST_STOP_CURRENT_CAP)
      else $error("fast stop current cap exceeded");
   chk_run_guard: assert property (                                   // see R17
      state_r == sss_pkg::SSS_IDLE && RUN_TERMINAL && !FAST_STOP_TERMINAL
      |=> state_r == sss_pkg::SSS_WAIT ##1 !DRIVE_EN)
      else $error("run accepted with fast stop active");

endmodule : sss_sequencer
`default_nettype wire

// file: sss_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer_test;
   localparam int T = 4;
   logic        clk, arst_n, zs, sen, run, fsn, csn, rg, cut, slow, pin;
   logic [15:0] ssi, sp, zl, ri, ro, tol, ssl, fr, cap, lim, pv, fb, dem, cl, cs;
   logic [12:0] nrt, crt, sto, hld, frd, fto;
   logic        snz, dnz, msf, zsr, trk, lq, thy, con, led, den;
   logic [2:0]  st;
   int          bad_count, checks, n;
   ////////////////////////////////////////
   // Block under test and the drive behind it
   sss_sequencer #(.RAMP_TICK_CYC(T)) dut_u (.CLK(clk), .ARST_N(arst_n), .SPEED_FB(fb),
      .STANDSTILL_IN(ssi), .SPEED_SETPOINT(sp), .ZERO_LEVEL_SET(zs), .ZERO_LEVEL(zl),
      .STANDSTILL_EN(sen), .RAMP_IN(ri), .RAMP_OUT(ro), .TRACKING_TOLERANCE(tol),
      .RUN_TERMINAL(run), .FAST_STOP_TERMINAL(fsn), .COAST_STOP_N(csn), .REGEN(rg),
      .NORMAL_RAMP_TIME(nrt), .COAST_RAMP_TIME(crt), .STOP_TIMEOUT(sto),
      .CONTACTOR_HOLD(hld), .STOP_SPEED_LEVEL(ssl), .CURRENT_DEMAND_CUT(cut),
      .CURRENT_FADE_RATE(fr), .FAST_RAMP_DURATION(frd), .FAST_STOP_TIMEOUT(fto),
      .FAST_STOP_CURRENT_CAP(cap), .CURRENT_LIMIT_IN(lim), .SPEED_NEAR_ZERO(snz),
      .DEMAND_NEAR_ZERO(dnz), .MOTOR_STOPPED_FLAG(msf), .ZERO_SPEED_RELAY(zsr),
      .TRACKING_FLAG(trk), .LOOPS_QUENCH(lq), .THYRISTOR_FIRING(thy), .CONTACTOR_ON(con),
      .RUN_LED(led), .DRIVE_EN(den), .SPEED_DEMAND(dem), .CURRENT_LIMIT(cl),
      .CURRENT_SCALE(cs), .SEQ_STATE(st));
   sss_drive_model drv_u (.clk(clk), .arst_n(arst_n), .demand(dem), .drive_en(den),
      .slow(slow), .pin(pin), .pin_val(pv), .fb(fb));
   ////////////////////////////////////////
   // Shared helpers
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic ck(input string nm, input logic [15:0] sn, input logic [15:0] ex);
      checks++;
      if (sn !== ex)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, ex, sn);
      end
   endtask : ck
   task automatic tk(input int k);
      repeat (k) @(negedge clk);
   endtask : tk
   function automatic logic [15:0] inr(input int lo, input int hi);
      return {15'h0000, n >= lo && n <= hi};
   endfunction : inr
   function automatic bit hit(input int k, input logic [2:0] s);
      case (k)
         0: return st === s;
         1: return con === 1'b0;
         default: return dem === 16'h0000;
      endcase
   endfunction : hit
   // Bounded wait, clocks spent left in n
   task automatic wt(input int k, input logic [2:0] s, input int lim_c);
      n = 0;
      while (!hit(k, s))
      begin
         @(negedge clk);
         n++;
         if (n > lim_c)
         begin
            bad_count++;
            $display("BAD wait %0d expected %h seen %h", k, s, st);
            print_verdict();
         end
      end
   endtask : wt
   // Run raised, stop inputs untouched; waits for RUN, checks contactor and enable
   task automatic go;
      @(posedge clk);
      run <= 1'b1;
      wt(0, sss_pkg::SSS_RUN, 8);
      tk(1);
      ck("run", {14'h0, con, den}, 16'h0003);
   endtask : go
   ////////////////////////////////////////
   // Scenarios
   task automatic t_zero;
      logic [15:0] v [7] = '{16'hFED5, 16'h0140, 16'h015E, 16'h0140, 16'h270F, 16'h00FA, 16'h00C7};
      logic [15:0] l [7] = '{16'h012C, 16'h012C, 16'h012C, 16'h012C, 16'h4E20, 16'h0, 16'h0};
      logic        d [7] = '{1, 1, 0, 0, 1, 0, 1};
      ck("reset", cs, 16'h2710);
      ck("reset", {11'h000, st, con, den}, 16'h0000);
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         pin <= 1'b1;
         pv <= v[i];
         ssi <= v[i];
         zl <= l[i];
         zs <= (i < 5);
         tk(3);
         ck("near zero", {snz, dnz, msf, zsr}, {4{d[i]}});
      end
      @(posedge clk);
      ssi <= 16'h1388;
      tk(3);
      ck("stopped", {snz, dnz, msf}, 3'b100);
      $display("zero levels done");
   endtask : t_zero
   task automatic t_track;
      logic [15:0] a [3] = '{16'h03E8, 16'h03E8, 16'hFF9C};
      logic [15:0] b [3] = '{16'h03B6, 16'h03B6, 16'h0000};
      logic [15:0] t [3] = '{16'h0064, 16'h0032, 16'h0065};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         ri <= a[i];
         ro <= b[i];
         tol <= t[i];
         tk(2);
         ck("tracking", trk, i != 1);
      end
      $display("tracking done");
   endtask : t_track
   task automatic t_quench;
      @(posedge clk);
      pv <= 16'h0000;
      ssi <= 16'h0000;
      sen <= 1'b1;
      go();
      tk(3);
      ck("quench", {lq, thy, con, led}, 4'hB);
      @(posedge clk);
      ssi <= 16'h03E8;
      tk(3);
      ck("unquench", {lq, thy, con, led}, 4'h7);
      @(posedge clk);
      sen <= 1'b0;
      run <= 1'b0;
      wt(0, sss_pkg::SSS_IDLE, 400);
      $display("standstill done");
   endtask : t_quench
   task automatic t_nstop(input logic r, input logic [15:0] lv, input logic [15:0] f,
                          input logic c, input int lo, input int hi);
      @(posedge clk);
      pin <= 1'b0;
      cut <= c;
      rg <= r;
      slow <= !r;
      ssl <= lv;
      fr <= f;
      sp <= 16'h1388;
      go();
      tk(10);
      @(posedge clk);
      run <= 1'b0;
      wt(2, 3'h0, 600);
      ck("ramp time", inr(lo, hi), 16'h0001);
      wt(0, sss_pkg::SSS_HOLD, 300);
      tk(2);
      ck("hold", {con, den}, {1'b1, !((lv > 16'h0019 || c) && f == 16'h0)});
      wt(1, 3'h0, 200);
      ck("hold time", inr(78, 128), 16'h0001);
      if (f != 16'h0000)
      begin
         ck("fade", st, sss_pkg::SSS_FADE);
         tk(42);
         ck("fade scale", cs < 16'h2710, 16'h0001);
      end
      wt(0, sss_pkg::SSS_IDLE, 5000);
      $display("normal stop done");
   endtask : t_nstop
   task automatic t_tmo;
      @(posedge clk);
      nrt <= 13'h03E8;
      sto <= 13'h0002;
      pin <= 1'b1;
      pv <= 16'h1388;
      go();
      @(posedge clk);
      run <= 1'b0;
      wt(1, 3'h0, 200);
      ck("stop timeout", {inr(40, 88), den}, {16'h0001, 1'b0});
      @(posedge clk);
      pin <= 1'b0;
      nrt <= 13'h000A;
      wt(0, sss_pkg::SSS_IDLE, 100);
      $display("stop timeout done");
   endtask : t_tmo
   task automatic t_fast(input logic p);
      @(posedge clk);
      pin <= p;
      slow <= 1'b0;
      fto <= p ? 13'h0002 : 13'h0FFF;
      lim <= 16'h1388;
      go();
      tk(10);
      @(posedge clk);
      fsn <= 1'b0;
      wt(0, sss_pkg::SSS_FSTOP, 4);
      tk(2);
      ck("cap", cl, cap);
      @(posedge clk);
      lim <= 16'h07D0;
      tk(3);
      ck("cap", cl, 16'h07D0);
      wt(1, 3'h0, 200);
      if (p)
         ck("fast timeout", inr(36, 78), 16'h0001);
      else
         ck("fast stop", {inr(80, 110), $signed(fb) < 100}, 17'h3);
      ck("fast off", den, 1'b0);
      @(posedge clk);
      fsn <= 1'b1;
      run <= 1'b0;
      pin <= 1'b0;
      wt(0, sss_pkg::SSS_IDLE, 100);
      $display("fast stop done");
   endtask : t_fast
   // Run applied while a stop is held, then coast in mid-run
   task automatic t_refuse(input logic c);
      @(posedge clk);
      fsn <= c;
      csn <= !c;
      @(posedge clk);
      run <= 1'b1;
      tk(10);
      ck("refused", {st, con, den}, {sss_pkg::SSS_WAIT, 2'b00});
      @(posedge clk);
      fsn <= 1'b1;
      csn <= 1'b1;
      run <= 1'b0;
      wt(0, sss_pkg::SSS_IDLE, 10);
      go();
      @(posedge clk);
      csn <= 1'b0;
      tk(2);
      ck("coast", {st, con, den}, {sss_pkg::SSS_WAIT, 2'b00});
      @(posedge clk);
      csn <= 1'b1;
      run <= 1'b0;
      wt(0, sss_pkg::SSS_IDLE, 10);
      $display("refusal done");
   endtask : t_refuse
   ////////////////////////////////////////
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Main sequence
   initial
   begin
      {arst_n, zs, sen, run, rg, cut, slow, pin} = '0;
      {fsn, csn} = 2'b11;
      {ssi, sp, zl, ri, ro, tol, fr, pv} = '0;
      ssl = 16'h0064;
      cap = 16'h0BB8;
      lim = 16'h1388;
      {nrt, crt, sto, hld} = {13'h000A, 13'h0014, 13'h0FFF, 13'h0003};
      {frd, fto} = {13'h0005, 13'h0FFF};
      bad_count = 0;
      checks = 0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_zero();
      t_track();
      t_quench();
      t_nstop(1'b1, 16'h0064, 16'h0000, 1'b0, 190, 210);
      t_nstop(1'b0, 16'h0014, 16'h03E8, 1'b0, 390, 410);
      t_nstop(1'b1, 16'h0014, 16'h0000, 1'b1, 190, 210);
      t_tmo();
      t_fast(1'b0);
      t_fast(1'b1);
      t_refuse(1'b0);
      t_refuse(1'b1);
      print_verdict();
   end
endmodule : sss_sequencer_test
`default_nettype wire
